// File: design/smmsm_pkg.sv
// ==========================================================
// Package of the safety module mode and state machine
// ==========================================================
package smmsm_pkg;

  // ========================================================
  // Register map
  // ========================================================
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS       = 8'h04;
  localparam int          CTRL_CFG_ENTER = 0;
  localparam int          CTRL_CFG_EXIT  = 1;
  localparam int          CTRL_PASS_CMD  = 2;
  localparam logic        CTRL_PASS_RST  = 1'h0;
  localparam int          STAT_ST_LSB    = 0;
  localparam int          STAT_BITS_LSB  = 8;
  localparam int          STAT_PARAM_OK  = 16;
  localparam int          STAT_TEST_DONE = 17;

  // ========================================================
  // Timing
  // ========================================================
  localparam int CLK_PERIOD_NS = 8;
  localparam int SELFTEST_NS   = 2000;
  // A least time, so the cycle count rounds up.
  localparam int SELFTEST_CYC  =
    (SELFTEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================================
  // Mode codes
  // ========================================================
  localparam logic [1:0] MODE_STARTUP  = 2'h0;
  localparam logic [1:0] MODE_RUN      = 2'h1;
  localparam logic [1:0] MODE_FAILSAFE = 2'h2;
  localparam logic [1:0] MODE_CONFIG   = 2'h3;

  // ========================================================
  // Types
  // ========================================================
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_CONFIG,
    ST_FAILSAFE,
    ST_OPER,
    ST_SAFE_ACK,
    ST_SAFE_PASS,
    ST_SAFE_REINT,
    ST_SAFE_CMD
  } smmsm_state_t;

  typedef struct packed {
    logic oaReq;
    logic fvActivated;
    logic deviceFault;
    logic opModeCodeHi;
    logic opModeCodeLo;
    logic localAckRequestFlag;
    logic linkAckRequestFlag;
    logic safeStateFlag;
  } smmsm_status_t;

endpackage

// File: design/smmsm_selftest.sv
`timescale 1ns/1ns
// ==========================================================
// Start-up hardware initialisation and self-test timer
// ==========================================================
module smmsm_selftest #(
  parameter int CYC = smmsm_pkg::SELFTEST_CYC
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic start,
  output logic      done
);

  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } smmsm_test_t;

  smmsm_test_t r;
  smmsm_test_t n;

  always_comb begin
    n = r;
    if (start) begin
      n.cnt  = '0;
      n.done = 1'b0;
    end else if (!r.done) begin
      if (r.cnt == CW'(CYC - 1)) begin
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
  end

  // Reset restarts the test, so power-up always runs it once.
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done = r.done;

endmodule

// File: design/smmsm_core.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
// ==========================================================
// Mode and state machine of the safety module
// ==========================================================
// Function
// - Start-up, config, fail-safe modes; oper plus four safe states.
// - Link configured: stay in start-up until valid parameters arrive.
// - Enter config from any mode or state but fail-safe, only while not modulating.
// - Configuration mode goes on to start-up mode, or to fail-safe on fatal error.
// - Ack request set only in the safe state awaiting acknowledgement.
// - Fail-safe-value flag set in safe states; channels forced zero.
// - Device fault bit is one exactly in fail-safe mode.
// - Start-up entry runs init and self-test before parameters count.
// - After parameters, wait for the host to open safety communication.
// - Stay in start-up while parameters fail or pend, or link pends.
// - Start-up reports 0,1,0, mode 00, ack flags 0, state flag 1.
// - Operational needs running link, no errors; reports 0,0,0, mode 01.
module smmsm_core #(
  parameter int NCH     = 8,
  parameter int TST_CYC = smmsm_pkg::SELFTEST_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic [31:0]                  regRdata,
  input  wire logic                    linkConfigured,
  input  wire logic                    paramValid,
  input  wire logic                    paramFail,
  input  wire logic                    commRunning,
  input  wire logic                    commError,
  input  wire logic                    appError,
  input  wire logic                    fatalError,
  input  wire logic                    modulating,
  input  wire logic                    localAck,
  input  wire logic                    linkAck,
  input  wire logic                    autoAck,
  input  wire logic                    localAckAvail,
  input  wire logic                    linkAckAvail,
  input  wire logic                    oaC,
  input  wire logic [NCH-1:0]          chIn,
  output logic [NCH-1:0]               chOut,
  output smmsm_pkg::smmsm_status_t     status
);

  // ========================================================
  // State
  // ========================================================
  typedef struct packed {
    smmsm_pkg::smmsm_state_t  st;
    logic                     paramOk;
    logic                     linkAckD;
    logic                     cfgReq;
    logic                     cfgExit;
    logic                     passCmd;
    logic [NCH-1:0]           chOut;
    smmsm_pkg::smmsm_status_t stat;
    logic [31:0]              rdata;
  } smmsm_core_t;

  smmsm_core_t r;
  smmsm_core_t n;
  logic        testStart;
  logic        testDone;
  logic        wrCtrl;
  logic        cfgSet;
  logic        cfgTaken;
  logic        reintAck;
  logic        noErr;
  logic [NCH-1:0] chPass;

  // ========================================================
  // Status decode
  // ========================================================
  function automatic smmsm_pkg::smmsm_status_t decode(
    input smmsm_pkg::smmsm_state_t st,
    input logic                    locAv,
    input logic                    lnkAv
  );
    smmsm_pkg::smmsm_status_t s;
    logic [1:0]               m;
    s = '0;
    m = smmsm_pkg::MODE_RUN;
    case (st)
      smmsm_pkg::ST_STARTUP: begin
        m = smmsm_pkg::MODE_STARTUP;
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
      smmsm_pkg::ST_CONFIG: begin
        m = smmsm_pkg::MODE_CONFIG;
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
      smmsm_pkg::ST_FAILSAFE: begin
        m = smmsm_pkg::MODE_FAILSAFE;
        s.deviceFault   = 1'b1;
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
      smmsm_pkg::ST_OPER: begin
        m = smmsm_pkg::MODE_RUN;
      end
      smmsm_pkg::ST_SAFE_ACK: begin
        s.oaReq         = 1'b1;
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
      smmsm_pkg::ST_SAFE_REINT: begin
        s.fvActivated         = 1'b1;
        s.safeStateFlag       = 1'b1;
        s.localAckRequestFlag = locAv;
        s.linkAckRequestFlag  = lnkAv;
      end
      smmsm_pkg::ST_SAFE_PASS,
      smmsm_pkg::ST_SAFE_CMD: begin
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
      default: begin
        s.fvActivated   = 1'b1;
        s.safeStateFlag = 1'b1;
      end
    endcase
    s.opModeCodeHi = m[1];
    s.opModeCodeLo = m[0];
    return s;
  endfunction

  // ========================================================
  // Self-test timer
  // ========================================================
  smmsm_selftest #(
    .CYC (TST_CYC)
  ) u_test (
    .mclk  (mclk),
    .srst  (srst),
    .start (testStart),
    .done  (testDone)
  );

  // Every fresh entry into start-up reruns the test.
  assign testStart = (n.st == smmsm_pkg::ST_STARTUP) &&
                     (r.st != smmsm_pkg::ST_STARTUP);

  // ========================================================
  // Channel gating
  // ========================================================
  // Gating uses the next fail-safe flag so that channels and
  // status change in the same cycle.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign chPass[i] = chIn[i] & ~n.stat.fvActivated;
  end

  // ========================================================
  // Next state
  // ========================================================
  assign wrCtrl  = regWr && (regAddr == smmsm_pkg::CTRL_OFS);
  assign cfgSet  = wrCtrl && regWdata[smmsm_pkg::CTRL_CFG_ENTER];
  assign noErr   = commRunning && !commError && !appError;
  // Link acknowledge counts only on its rising edge.
  assign reintAck = localAck || autoAck || (linkAck && !r.linkAckD);

  always_comb begin
    n          = r;
    n.rdata    = 32'h0;
    n.linkAckD = linkAck;
    n.cfgExit  = wrCtrl && regWdata[smmsm_pkg::CTRL_CFG_EXIT];
    cfgTaken   = 1'b0;
    if (wrCtrl) begin
      n.passCmd = regWdata[smmsm_pkg::CTRL_PASS_CMD];
    end

    // Parameters are only gathered while in start-up.
    if (r.st == smmsm_pkg::ST_STARTUP) begin
      if (paramFail) begin
        n.paramOk = 1'b0;
      end else if (paramValid && testDone) begin
        n.paramOk = 1'b1;
      end
    end

    case (r.st)
      smmsm_pkg::ST_STARTUP: begin
        // Host opens the link; we only watch it run.
        if (linkConfigured && r.paramOk && testDone &&
            noErr) begin
          n.st = smmsm_pkg::ST_OPER;
        end
      end
      smmsm_pkg::ST_CONFIG: begin
        if (r.cfgExit) begin
          n.st = smmsm_pkg::ST_STARTUP;
        end
      end
      smmsm_pkg::ST_FAILSAFE: begin
        // Left only by reset or power cycle.
        n.st = smmsm_pkg::ST_FAILSAFE;
      end
      smmsm_pkg::ST_OPER: begin
        if (commError || !commRunning) begin
          n.st = smmsm_pkg::ST_SAFE_PASS;
        end else if (appError) begin
          n.st = smmsm_pkg::ST_SAFE_REINT;
        end else if (r.passCmd) begin
          n.st = smmsm_pkg::ST_SAFE_CMD;
        end
      end
      smmsm_pkg::ST_SAFE_PASS: begin
        if (commRunning && !commError) begin
          n.st = smmsm_pkg::ST_SAFE_ACK;
        end
      end
      smmsm_pkg::ST_SAFE_ACK: begin
        if (commError || !commRunning) begin
          n.st = smmsm_pkg::ST_SAFE_PASS;
        end else if (oaC && !appError) begin
          n.st = smmsm_pkg::ST_OPER;
        end
      end
      smmsm_pkg::ST_SAFE_REINT: begin
        if (commError || !commRunning) begin
          n.st = smmsm_pkg::ST_SAFE_PASS;
        end else if (!appError && reintAck) begin
          n.st = smmsm_pkg::ST_OPER;
        end
      end
      smmsm_pkg::ST_SAFE_CMD: begin
        if (commError || !commRunning) begin
          n.st = smmsm_pkg::ST_SAFE_PASS;
        end else if (!r.passCmd && noErr) begin
          n.st = smmsm_pkg::ST_OPER;
        end
      end
      default: begin
        n.st = smmsm_pkg::ST_STARTUP;
      end
    endcase

    // Configuration outranks every other move but fatal error.
    if (r.st != smmsm_pkg::ST_CONFIG && r.st != smmsm_pkg::ST_FAILSAFE
        && r.cfgReq && !modulating) begin
      n.st     = smmsm_pkg::ST_CONFIG;
      cfgTaken = 1'b1;
    end
    if (r.st == smmsm_pkg::ST_CONFIG) begin
      cfgTaken = 1'b1;
    end
    if (fatalError) begin
      n.st = smmsm_pkg::ST_FAILSAFE;
    end

    // A request written in the cycle it is consumed survives.
    n.cfgReq = cfgSet || (r.cfgReq && !cfgTaken);

    if (testStart) begin
      n.paramOk = 1'b0;
    end

    n.stat  = decode(n.st, localAckAvail && !autoAck,
                     linkAckAvail && !autoAck);
    n.chOut = chPass;

    // Read data stand only in the cycle after the strobe.
    if (regRd) begin
      case (regAddr)
        smmsm_pkg::CTRL_OFS: begin
          n.rdata[smmsm_pkg::CTRL_PASS_CMD] = r.passCmd;
          n.rdata[smmsm_pkg::CTRL_CFG_ENTER] = r.cfgReq;
        end
        smmsm_pkg::STAT_OFS: begin
          n.rdata[smmsm_pkg::STAT_ST_LSB +: 3] = r.st;
          n.rdata[smmsm_pkg::STAT_BITS_LSB +: 8] = r.stat;
          n.rdata[smmsm_pkg::STAT_PARAM_OK] = r.paramOk;
          n.rdata[smmsm_pkg::STAT_TEST_DONE] = testDone;
        end
        default: begin
          n.rdata = 32'h0;
        end
      endcase
    end
  end

  // ========================================================
  // Registers
  // ========================================================
  always_ff @(posedge mclk) begin
    if (srst) begin
      r         <= '0;
      r.st      <= smmsm_pkg::ST_STARTUP;
      r.passCmd <= smmsm_pkg::CTRL_PASS_RST;
      r.stat    <= decode(smmsm_pkg::ST_STARTUP, 1'b0, 1'b0);
      r.chOut   <= '0;
    end else begin
      r <= n;
    end
  end

  assign regRdata = r.rdata;
  assign chOut    = r.chOut;
  assign status   = r.stat;

endmodule

// File: test/smmsm_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Port assertions for the mode and state machine
// ==========================================================
module smmsm_checker #(
  parameter int NCH     = 8,
  parameter int TST_CYC = 4
) (
  input wire logic                     mclk,
  input wire logic                     srst,
  input wire logic                     linkConfigured,
  input wire logic                     commRunning,
  input wire logic                     commError,
  input wire logic                     fatalError,
  input wire logic                     modulating,
  input wire logic [NCH-1:0]           chIn,
  input wire logic [NCH-1:0]           chOut,
  input wire smmsm_pkg::smmsm_status_t status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence inConfig;
    (status == 8'h59) && !fatalError;
  endsequence
  sequence leftConfig;
    status != 8'h59;
  endsequence

  AST_RESET_STATE: assert property (
    disable iff (1'b0) srst |=> (status == 8'h41) && (chOut == '0))
    else $error("reset did not give start-up status");
  // The self-test length here matches the TST_CYC given by the bench.
  AST_SELFTEST_HOLD: assert property (
    $fell(srst) |-> (status == 8'h41) [*4])
    else $error("start-up left before self-test time");
  AST_CONFIG_EXIT: assert property (
    inConfig ##1 leftConfig |-> status == 8'h41)
    else $error("configuration left to a mode other than start-up");
  AST_CONFIG_ENTRY: assert property (
    (status != 8'h59) && modulating |=> status != 8'h59)
    else $error("configuration entered while modulating");
  AST_ACK_REQ: assert property (
    status.oaReq |-> status == 8'hC9)
    else $error("acknowledge request outside the awaiting state");
  AST_FV_ZERO: assert property (
    status.fvActivated |-> chOut == '0)
    else $error("channels not forced to zero");
  AST_PASS_THRU: assert property (
    !status.fvActivated |-> chOut == $past(chIn))
    else $error("channels not passed through in operational");
  AST_OPER_BITS: assert property (
    !status.fvActivated |-> status == 8'h08)
    else $error("operational status bits wrong");
  AST_STARTUP_HOLD: assert property (
    (status == 8'h41) && !(commRunning && linkConfigured && !commError)
      |=> status != 8'h08)
    else $error("operational reached without running link");
  AST_FATAL: assert property (
    fatalError |=> (status == 8'h71) && status.deviceFault)
    else $error("fatal error did not give fail-safe");
  AST_FAULT_BIT: assert property (
    status.deviceFault == (status.opModeCodeHi && !status.opModeCodeLo))
    else $error("device fault bit not tied to fail-safe mode");
endmodule

bind smmsm_core smmsm_checker #(.NCH(NCH), .TST_CYC(TST_CYC)) u_smmsm_checker (
  .mclk(mclk), .srst(srst), .linkConfigured(linkConfigured),
  .commRunning(commRunning), .commError(commError),
  .fatalError(fatalError), .modulating(modulating), .chIn(chIn),
  .chOut(chOut), .status(status));

// File: test/smmsm_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Safety controller on the far side of the safety link
// ==========================================================
module smmsm_host_model (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     giveParam,
  input  wire logic                     openComm,
  input  wire logic                     confirmAck,
  input  wire smmsm_pkg::smmsm_status_t status,
  output logic                          paramValid,
  output logic                          commRunning,
  output logic                          oaC
);
  always_ff @(posedge mclk) begin
    if (srst) begin
      paramValid  <= 1'b0;
      commRunning <= 1'b0;
      oaC         <= 1'b0;
    end else begin
      paramValid  <= giveParam;
      commRunning <= openComm;
      // The host confirms only while the device asks for it.
      oaC         <= confirmAck && status.oaReq;
    end
  end
endmodule

// File: test/smmsm_core_bench.sv
`timescale 1ns/1ns
// ==========================================================
// Bench of the mode and state machine
// ==========================================================
module smmsm_core_bench;
  logic        mclk, srst, regWr, regRd, linkConfigured, paramFail;
  logic        commError, appError, fatalError, modulating, localAck;
  logic        linkAck, autoAck, localAckAvail, linkAckAvail;
  logic        giveParam, openComm, confirmAck, paramValid, commRunning;
  logic        oaC;
  logic [7:0]  regAddr, chIn, chOut;
  logic [31:0] regWdata, regRdata, d;
  smmsm_pkg::smmsm_status_t status;
  int          fail_count, n_compared;

  smmsm_core #(.NCH(8), .TST_CYC(4)) u_smmsm_core (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .linkConfigured(linkConfigured), .paramValid(paramValid),
    .paramFail(paramFail), .commRunning(commRunning),
    .commError(commError), .appError(appError), .fatalError(fatalError),
    .modulating(modulating), .localAck(localAck), .linkAck(linkAck),
    .autoAck(autoAck), .localAckAvail(localAckAvail),
    .linkAckAvail(linkAckAvail), .oaC(oaC), .chIn(chIn), .chOut(chOut),
    .status(status));
  smmsm_host_model u_smmsm_host_model (
    .mclk(mclk), .srst(srst), .giveParam(giveParam), .openComm(openComm),
    .confirmAck(confirmAck), .status(status), .paramValid(paramValid),
    .commRunning(commRunning), .oaC(oaC));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ========================================================
  // Tasks
  // ========================================================
  task automatic tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_status(input logic [7:0] exp);
    n_compared++;
    if (status !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t status %h exp %h", $time, status, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
    end
  endtask
  // A bounded wait: a missed state ends the run at once.
  task automatic wait_status(input logic [7:0] exp);
    for (int i = 0; i < 40 && status !== exp; i++) begin
      @(posedge mclk);
      #1;
    end
    cmp_status(exp);
    if (status !== exp) tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask

  // ========================================================
  // Main sequence
  // ========================================================
  initial begin
    {regWr, regRd, linkConfigured, paramFail, commError, appError} = '0;
    {fatalError, modulating, localAck, linkAck, autoAck} = '0;
    {localAckAvail, linkAckAvail, giveParam, openComm, confirmAck} = '0;
    {regAddr, chIn, regWdata} = '0;
    fail_count = 0;
    n_compared = 0;
    srst = 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    cmp_status(8'h41);
    cmp_word({24'h0, chOut}, 32'h0);
    @(posedge mclk);
    linkConfigured <= 1'b1;
    openComm <= 1'b1;
    chIn <= 8'hA5;
    repeat (10) @(posedge mclk);
    #1;
    cmp_status(8'h41);
    rd(smmsm_pkg::STAT_OFS, d);
    cmp_word(d, 32'h0002_4100);
    @(posedge mclk);
    giveParam <= 1'b1;
    wait_status(8'h08);
    cmp_word({24'h0, chOut}, 32'hA5);
    @(posedge mclk);
    commError <= 1'b1;
    wait_status(8'h49);
    cmp_word({24'h0, chOut}, 32'h0);
    @(posedge mclk);
    commError <= 1'b0;
    wait_status(8'hC9);
    repeat (4) @(posedge mclk);
    #1;
    cmp_status(8'hC9);
    confirmAck <= 1'b1;
    wait_status(8'h08);
    @(posedge mclk);
    confirmAck <= 1'b0;
    appError <= 1'b1;
    localAckAvail <= 1'b1;
    linkAckAvail <= 1'b1;
    wait_status(8'h4F);
    @(posedge mclk);
    appError <= 1'b0;
    linkAck <= 1'b1;
    wait_status(8'h08);
    @(posedge mclk);
    {linkAck, localAckAvail, linkAckAvail} <= 3'h0;
    wr(smmsm_pkg::CTRL_OFS, 32'h0000_0004);
    wait_status(8'h49);
    rd(smmsm_pkg::STAT_OFS, d);
    cmp_word(d, 32'h0003_4907);
    wr(smmsm_pkg::CTRL_OFS, 32'h0000_0000);
    wait_status(8'h08);
    @(posedge mclk);
    modulating <= 1'b1;
    wr(smmsm_pkg::CTRL_OFS, 32'h0000_0001);
    rd(smmsm_pkg::CTRL_OFS, d);
    cmp_word(d, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    #1;
    cmp_status(8'h08);
    modulating <= 1'b0;
    wait_status(8'h59);
    wr(smmsm_pkg::CTRL_OFS, 32'h0000_0002);
    wait_status(8'h41);
    rd(8'h08, d);
    cmp_word(d, 32'h0); // unmapped offset reads zero
    @(posedge mclk);
    fatalError <= 1'b1;
    wait_status(8'h71);
    @(posedge mclk);
    fatalError <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    cmp_status(8'h71);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1;
    cmp_status(8'h41);
    tally_and_finish();
  end
endmodule
